/* File: verilog/sdr_consts.svh */
// Constants of the safety data object receiver: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the design files.
`ifndef SDR_CONSTS_SVH
`define SDR_CONSTS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define SDR_OFS_CTRL 8'h00
`define SDR_OFS_INDEX 8'h04
`define SDR_OFS_IDS 8'h08
`define SDR_OFS_TIMES 8'h0C
`define SDR_OFS_STATUS 8'h10
`define SDR_OFS_DATA_LO 8'h14
`define SDR_OFS_DATA_HI 8'h18

// ****************************************
// Field positions
// ****************************************
`define SDR_CTRL_RUN 0
`define SDR_CTRL_LOAD 1
`define SDR_IDS_INV_LSB 16
`define SDR_TIMES_VALIDATION_TIME_LIMIT_LSB 16
`define SDR_ST_FAULT 4
`define SDR_ST_LINK 5
`define SDR_ST_SAFE 6
`define SDR_ST_NEW 7
`define SDR_ST_GFC 8
`define SDR_ST_CH_LSB 12
`define SDR_ST_LEN_LSB 16

// ****************************************
// Reset values and fixed codes
// ****************************************
`define SDR_RST_WORD 32'h0000_0000
`define SDR_RST_IDS 32'h0000_0000
`define SDR_RST_TIMES 32'h0028_0096
`define SDR_GFC_ID 11'h001
`define SDR_NUM_CH 8
`define SDR_MAX_LEN 4'h8

// ****************************************
// Timing
// ****************************************
`define SDR_CLK_PERIOD_NS 40
`define SDR_TICK_PERIOD_NS 1000000
`define SDR_TICK_CYCLES (`SDR_TICK_PERIOD_NS / `SDR_CLK_PERIOD_NS)

`endif

/* File: verilog/sdr_pkg.sv */
// Types shared by the safety data object receiver.
// Assumes nothing beyond a SystemVerilog compiler.
package sdr_pkg;
   typedef logic [10:0] sdr_id_t;
   typedef logic [15:0] sdr_ms_t;
   typedef logic [2:0] sdr_ch_t;
   typedef enum logic [1:0] {
      SDR_CFG_OK,
      SDR_CFG_BAD_IDS,
      SDR_CFG_BAD_INDEX,
      SDR_CFG_RUNNING
   } sdr_cfg_result_t;
endpackage

/* File: verilog/sdr_tick_gen.sv */
// Service tick generator: one pclk-wide pulse per processing period.
// Assumes a free-running pclk and asynchronous active-low reset.
module sdr_tick_gen import sdr_pkg::*; #(
   parameter int TICK_CYCLES = 25000
) (
   input wire logic pclk,
   input wire logic presetn,
   output logic tick
);
   logic [15:0] count_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg <= 16'h0000;
         tick <= 1'b0;
      end else if (count_reg == 16'(TICK_CYCLES - 1)) begin
         count_reg <= 16'h0000;
         tick <= 1'b1;
      end else begin
         count_reg <= count_reg + 16'h0001;
         tick <= 1'b0;
      end
   end
endmodule // sdr_tick_gen

/* File: verilog/sdr_pair_check.sv */
// Inverse check of a normal frame against its inverted twin.
// Assumes both lengths are byte counts of at most eight.
`include "sdr_consts.svh"

module sdr_pair_check import sdr_pkg::*; (
   input wire logic [63:0] norm_data,
   input wire logic [3:0] norm_len,
   input wire logic [63:0] inv_data,
   input wire logic [3:0] inv_len,
   output logic pair_ok
);
   logic [7:0] byte_ok;

   // Bytes beyond the length are don't-care
   for (genvar i = 0; i < 8; i++) begin : g_byte
      assign byte_ok[i] = (4'(i) >= norm_len) ||
                          (inv_data[i*8 +: 8] == ~norm_data[i*8 +: 8]);
   end

   assign pair_ok = (norm_len == inv_len) && (norm_len <= `SDR_MAX_LEN) && (&byte_ok);
endmodule // sdr_pair_check

/* File: verilog/sdr_receiver.sv */
// Receive side of a safety data object channel set, with APB registers.
// Assumes frames arrive on the rx port in pclk domain, one per cycle at most.
//
// Summary of operation
// - Configuration loads only on config_load with run_enable low in the same write.
// - Without config_load the stored channel configuration never changes.
// - Up to eight channels, chosen by object_index.
// - config_result: 0 ok, 1 bad identifier pair, 2 bad index, 3 while running.
// - Running: accept frames, check them and both time limits, refuse reconfiguration.
// - Stopped: ignore safety frames, allow configuration changes.
// - At run start, freeze configuration and guard it with a checksum.
// - Normal data under primary_identifier, inverse under inverted_identifier; mismatch is fault.
// - No valid pair within cycle_time_limit: group fault and safe state.
// - Inverse frame later than validation_time_limit: group fault and safe state.
// - Valid pair stores payload and pulses new_data_pulse for one processing cycle.
// - Output the received length, the count of valid payload bytes.
// - Fault sets group fault, link fault flag and safe_state together; other outputs keep updating.
// - Global failsafe command raises global_failsafe_flag for one processing cycle.
// - One channel serviced per millisecond, eight channels every eight milliseconds.
// - Both CAN interfaces carry 11-bit identifiers only while safety runs.
`include "sdr_consts.svh"

module sdr_receiver import sdr_pkg::*; #(
   parameter int TICK_CYCLES = `SDR_TICK_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_valid,
   input wire logic rx_if,
   input wire logic rx_ext,
   input wire logic [10:0] rx_id,
   input wire logic [3:0] rx_dlc,
   input wire logic [63:0] rx_data,
   output logic [63:0] rx_payload,
   output logic [3:0] rx_length,
   output logic [2:0] rx_channel,
   output logic new_data_pulse,
   output logic [1:0] config_result,
   output logic group_fault,
   output logic safety_link_fault_flag,
   output logic safe_state,
   output logic global_failsafe_flag,
   output logic can_std_only
);
   // ********************
   // Declarations
   // ********************
   logic tick, pair_ok, run_enable_reg, run_d_reg, gfc_pending_reg, apb_ack, apb_wr;
   logic cfg_attempt, cfg_accept, rx_take, rx_gfc, svc_fault, svc_good, fault_now, rd_ok;
   logic [7:0] index_reg, cfg_used, have_norm, have_inv, order_err;
   logic [31:0] ids_reg, times_reg, frozen_sum_reg, live_sum, rd_word;
   sdr_ch_t svc_ptr_reg;
   sdr_id_t cfg_id1 [8], cfg_id2 [8];
   sdr_ms_t cfg_sct [8], cfg_validation_time_limit [8], sct_cnt [8], validation_time_limit_cnt [8];
   logic [63:0] norm_data [8], inv_data [8];
   logic [3:0] norm_len [8], inv_len [8], hit_norm, hit_inv;
   sdr_cfg_result_t cfg_result_next;

   // ********************
   // Helpers
   // ********************
   // Returns {hit, channel} of the first used channel with that identifier
   function automatic logic [3:0] find_ch(input sdr_id_t id, input logic inverted);
      logic [3:0] res;
      res = 4'h0;
      for (int c = `SDR_NUM_CH - 1; c >= 0; c--) begin
         if (cfg_used[c] && (id == (inverted ? cfg_id2[c] : cfg_id1[c]))) begin
            res = {1'b1, 3'(c)};
         end
      end
      return res;
   endfunction

   sdr_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick)
   );

   sdr_pair_check u_check (
      .norm_data(norm_data[svc_ptr_reg]),
      .norm_len(norm_len[svc_ptr_reg]),
      .inv_data(inv_data[svc_ptr_reg]),
      .inv_len(inv_len[svc_ptr_reg]),
      .pair_ok(pair_ok)
   );

   // ********************
   // APB slave
   // ********************
   // One wait state so that every bus output comes from a flip-flop
   assign apb_ack = psel && penable && pready;
   assign apb_wr = apb_ack && pwrite;

   always_comb begin
      rd_ok = 1'b1;
      rd_word = `SDR_RST_WORD;
      unique case (paddr)
         `SDR_OFS_CTRL: rd_word = {31'h0000_0000, run_enable_reg};
         `SDR_OFS_INDEX: rd_word = {24'h00_0000, index_reg};
         `SDR_OFS_IDS: rd_word = ids_reg;
         `SDR_OFS_TIMES: rd_word = times_reg;
         `SDR_OFS_STATUS: begin
            rd_word[1:0] = config_result;
            rd_word[`SDR_ST_FAULT] = group_fault;
            rd_word[`SDR_ST_LINK] = safety_link_fault_flag;
            rd_word[`SDR_ST_SAFE] = safe_state;
            rd_word[`SDR_ST_NEW] = new_data_pulse;
            rd_word[`SDR_ST_GFC] = global_failsafe_flag;
            rd_word[`SDR_ST_CH_LSB +: 3] = rx_channel;
            rd_word[`SDR_ST_LEN_LSB +: 4] = rx_length;
         end
         `SDR_OFS_DATA_LO: rd_word = rx_payload[31:0];
         `SDR_OFS_DATA_HI: rd_word = rx_payload[63:32];
         default: rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= `SDR_RST_WORD;
      end else begin
         pready <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !rd_ok;
         prdata <= (psel && penable && !pready && !pwrite) ? rd_word : `SDR_RST_WORD;
      end
   end

   // Staging registers are free to change; channel table is not
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         index_reg <= 8'h00;
         ids_reg <= `SDR_RST_IDS;
         times_reg <= `SDR_RST_TIMES;
         run_enable_reg <= 1'b0;
      end else if (apb_wr && rd_ok) begin
         unique case (paddr)
            `SDR_OFS_INDEX: index_reg <= pwdata[7:0];
            `SDR_OFS_IDS: ids_reg <= pwdata;
            `SDR_OFS_TIMES: times_reg <= pwdata;
            `SDR_OFS_CTRL: run_enable_reg <= pwdata[`SDR_CTRL_RUN];
            default: ;
         endcase
      end
   end

   // ********************
   // Configuration
   // ********************
   assign cfg_attempt = apb_wr && (paddr == `SDR_OFS_CTRL) && pwdata[`SDR_CTRL_LOAD];
   always_comb begin
      cfg_result_next = SDR_CFG_OK;
      if (pwdata[`SDR_CTRL_RUN] || run_enable_reg) begin
         cfg_result_next = SDR_CFG_RUNNING;
      end else if (index_reg >= 8'(`SDR_NUM_CH)) begin
         cfg_result_next = SDR_CFG_BAD_INDEX;
      end else if ((ids_reg[10:0] == ids_reg[`SDR_IDS_INV_LSB +: 11]) ||
                   (ids_reg[10:0] == `SDR_GFC_ID) ||
                   (ids_reg[`SDR_IDS_INV_LSB +: 11] == `SDR_GFC_ID)) begin
         cfg_result_next = SDR_CFG_BAD_IDS;
      end
   end
   assign cfg_accept = cfg_attempt && (cfg_result_next == SDR_CFG_OK);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         config_result <= 2'h0;
      end else if (cfg_attempt) begin
         config_result <= cfg_result_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_used <= 8'h00;
         for (int c = 0; c < `SDR_NUM_CH; c++) begin
            cfg_id1[c] <= 11'h000;
            cfg_id2[c] <= 11'h000;
            cfg_sct[c] <= 16'h0000;
            cfg_validation_time_limit[c] <= 16'h0000;
         end
      end else if (cfg_accept) begin
         cfg_used[index_reg[2:0]] <= 1'b1;
         cfg_id1[index_reg[2:0]] <= ids_reg[10:0];
         cfg_id2[index_reg[2:0]] <= ids_reg[`SDR_IDS_INV_LSB +: 11];
         cfg_sct[index_reg[2:0]] <= times_reg[15:0];
         cfg_validation_time_limit[index_reg[2:0]] <= times_reg[`SDR_TIMES_VALIDATION_TIME_LIMIT_LSB +: 16];
      end
   end

   // Checksum catches table upsets while running
   always_comb begin
      live_sum = {24'h00_0000, cfg_used};
      for (int c = 0; c < `SDR_NUM_CH; c++) begin
         live_sum = {live_sum[30:0], live_sum[31]} ^
                    {5'h00, cfg_id2[c], 5'h00, cfg_id1[c]} ^ {cfg_validation_time_limit[c], cfg_sct[c]};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_d_reg <= 1'b0;
         frozen_sum_reg <= `SDR_RST_WORD;
         can_std_only <= 1'b0;
      end else begin
         run_d_reg <= run_enable_reg;
         can_std_only <= run_enable_reg;
         if (run_enable_reg && !run_d_reg) begin
            frozen_sum_reg <= live_sum;
         end
      end
   end

   // ********************
   // Frame capture
   // ********************
   // Extended-format frames never belong to a safety channel
   assign rx_take = rx_valid && run_d_reg && !rx_ext;
   assign hit_norm = find_ch(rx_id, 1'b0);
   assign hit_inv = find_ch(rx_id, 1'b1);
   assign rx_gfc = rx_take && (rx_id == `SDR_GFC_ID);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         have_norm <= 8'h00;
         have_inv <= 8'h00;
         order_err <= 8'h00;
         for (int c = 0; c < `SDR_NUM_CH; c++) begin
            norm_data[c] <= 64'h0000_0000_0000_0000;
            inv_data[c] <= 64'h0000_0000_0000_0000;
            norm_len[c] <= 4'h0;
            inv_len[c] <= 4'h0;
            sct_cnt[c] <= 16'h0000;
            validation_time_limit_cnt[c] <= 16'h0000;
         end
      end else if (!run_d_reg) begin
         have_norm <= 8'h00;
         have_inv <= 8'h00;
         order_err <= 8'h00;
         for (int c = 0; c < `SDR_NUM_CH; c++) begin
            sct_cnt[c] <= 16'h0000;
            validation_time_limit_cnt[c] <= 16'h0000;
         end
      end else begin
         if (tick) begin
            for (int c = 0; c < `SDR_NUM_CH; c++) begin
               if (sct_cnt[c] != 16'hFFFF) begin
                  sct_cnt[c] <= sct_cnt[c] + 16'h0001;
               end
               if (validation_time_limit_cnt[c] != 16'hFFFF) begin
                  validation_time_limit_cnt[c] <= validation_time_limit_cnt[c] + 16'h0001;
               end
            end
            if (svc_good) begin
               have_norm[svc_ptr_reg] <= 1'b0;
               have_inv[svc_ptr_reg] <= 1'b0;
               sct_cnt[svc_ptr_reg] <= 16'h0000;
            end
         end
         // Capture after the service clear so a same-cycle frame is kept
         if (rx_take && hit_norm[3]) begin
            norm_data[hit_norm[2:0]] <= rx_data;
            norm_len[hit_norm[2:0]] <= rx_dlc;
            have_norm[hit_norm[2:0]] <= 1'b1;
            have_inv[hit_norm[2:0]] <= 1'b0;
            validation_time_limit_cnt[hit_norm[2:0]] <= 16'h0000;
         end else if (rx_take && hit_inv[3]) begin
            if (have_norm[hit_inv[2:0]]) begin
               inv_data[hit_inv[2:0]] <= rx_data;
               inv_len[hit_inv[2:0]] <= rx_dlc;
               have_inv[hit_inv[2:0]] <= 1'b1;
            end else begin
               order_err[hit_inv[2:0]] <= 1'b1;
            end
         end
      end
   end

   // ********************
   // Channel service
   // ********************
   always_comb begin
      svc_fault = 1'b0;
      svc_good = 1'b0;
      if (cfg_used[svc_ptr_reg]) begin
         if (order_err[svc_ptr_reg]) begin
            svc_fault = 1'b1;
         end else if (have_norm[svc_ptr_reg] && have_inv[svc_ptr_reg]) begin
            svc_good = pair_ok;
            svc_fault = !pair_ok;
         end else if (have_norm[svc_ptr_reg] &&
                      (validation_time_limit_cnt[svc_ptr_reg] >= cfg_validation_time_limit[svc_ptr_reg])) begin
            svc_fault = 1'b1;
         end else if (sct_cnt[svc_ptr_reg] >= cfg_sct[svc_ptr_reg]) begin
            svc_fault = 1'b1;
         end
      end
   end

   assign fault_now = run_d_reg && ((tick && svc_fault) || (live_sum != frozen_sum_reg));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         svc_ptr_reg <= 3'h0;
      end else if (tick) begin
         svc_ptr_reg <= svc_ptr_reg + 3'h1;
      end
   end

   // Flags last one processing cycle, i.e. until the next tick
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         new_data_pulse <= 1'b0;
         rx_payload <= 64'h0000_0000_0000_0000;
         rx_length <= 4'h0;
         rx_channel <= 3'h0;
      end else if (tick) begin
         new_data_pulse <= run_d_reg && svc_good;
         if (run_d_reg && svc_good) begin
            rx_payload <= norm_data[svc_ptr_reg];
            rx_length <= norm_len[svc_ptr_reg];
            rx_channel <= svc_ptr_reg;
         end
      end
   end

   // Set wins: a command on the tick edge still reaches the next slot
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gfc_pending_reg <= 1'b0;
         global_failsafe_flag <= 1'b0;
      end else if (tick) begin
         global_failsafe_flag <= gfc_pending_reg;
         gfc_pending_reg <= rx_gfc;
      end else if (rx_gfc) begin
         gfc_pending_reg <= 1'b1;
      end
   end

   // ********************
   // Fault latch
   // ********************
   // Only reset leaves the safe state; restart would mask a broken link
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         group_fault <= 1'b0;
         safety_link_fault_flag <= 1'b0;
         safe_state <= 1'b0;
      end else if (fault_now) begin
         group_fault <= 1'b1;
         safety_link_fault_flag <= 1'b1;
         safe_state <= 1'b1;
      end
   end
endmodule // sdr_receiver

/* File: tb/sdr_receiver_checker.sv */
// Port assertions for the safety data object receiver.
// Assumes binding into every sdr_receiver; one pclk domain.
module sdr_receiver_checker #(
   parameter int TICK_CYCLES = 25000
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [63:0] rx_payload,
   input wire logic [3:0] rx_length,
   input wire logic new_data_pulse,
   input wire logic [1:0] config_result,
   input wire logic group_fault,
   input wire logic safety_link_fault_flag,
   input wire logic safe_state,
   input wire logic global_failsafe_flag,
   input wire logic can_std_only
);
   timeunit 1ns;
   timeprecision 1ns;
   int new_cnt;
   int gfc_cnt;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // ********************
   // Pulse width counters
   // ********************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         new_cnt <= 0;
         gfc_cnt <= 0;
      end else begin
         new_cnt <= new_data_pulse ? new_cnt + 1 : 0;
         gfc_cnt <= global_failsafe_flag ? gfc_cnt + 1 : 0;
      end
   end

   // ********************
   // Assertions
   // ********************
   chk_fault_trio: assert property (
      group_fault == safety_link_fault_flag && group_fault == safe_state)
      else $error("fault outputs disagree");
   chk_fault_latch: assert property (group_fault |=> group_fault)
      else $error("group fault released before reset");
   chk_new_width: assert property ($fell(new_data_pulse) |-> new_cnt == TICK_CYCLES)
      else $error("new data pulse not one service period");
   chk_gfc_width: assert property (
      $fell(global_failsafe_flag) |-> gfc_cnt == TICK_CYCLES)
      else $error("failsafe flag not one service period");
   chk_new_when_run: assert property ($rose(new_data_pulse) |-> $past(can_std_only))
      else $error("new data while stopped");
   chk_payload_cause: assert property (!$stable(rx_payload) |-> $rose(new_data_pulse))
      else $error("payload changed without new data");
   chk_len_range: assert property (rx_length <= 4'h8)
      else $error("length above eight");
   chk_cfg_cause: assert property ($changed(config_result) |->
      $past(psel && penable && pready && pwrite && paddr == 8'h00))
      else $error("config result changed without a control write");
   chk_ready_wait: assert property (psel && penable && !pready |=> pready)
      else $error("access not answered after one wait state");
   chk_ready_once: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   chk_err_quiet: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error response malformed");
endmodule // sdr_receiver_checker

bind sdr_receiver sdr_receiver_checker #(.TICK_CYCLES(TICK_CYCLES)) sdr_receiver_checker_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .rx_payload(rx_payload), .rx_length(rx_length), .new_data_pulse(new_data_pulse),
   .config_result(config_result), .group_fault(group_fault),
   .safety_link_fault_flag(safety_link_fault_flag), .safe_state(safe_state),
   .global_failsafe_flag(global_failsafe_flag), .can_std_only(can_std_only));

/* File: tb/sdr_remote_node.sv */
// Remote transmitting node: puts safety frames on the receiver's rx port.
// Assumes callers enter its tasks from one process, in pclk domain.
module sdr_remote_node (
   input wire logic pclk,
   output logic rx_valid,
   output logic rx_if,
   output logic rx_ext,
   output logic [10:0] rx_id,
   output logic [3:0] rx_dlc,
   output logic [63:0] rx_data
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      {rx_valid, rx_if, rx_ext} = 3'h0;
      {rx_id, rx_dlc, rx_data} = {11'h7FF, 4'hF, 64'h0};
   end

   task automatic send(input logic [10:0] id, input logic [3:0] dlc, input logic [63:0] d,
                       input logic ext);
      @(posedge pclk);
      rx_valid <= 1'b1;
      rx_ext <= ext;
      rx_id <= id;
      rx_dlc <= dlc;
      rx_data <= d;
      @(posedge pclk);
      rx_valid <= 1'b0;
      rx_if <= ~rx_if;
      // Released lines show the inverse, never the stale frame
      rx_id <= ~id;
      rx_dlc <= ~dlc;
      rx_data <= ~d;
   endtask

   // Flip marks deliberate inverse errors commanded by the bench
   task automatic pair(input logic [10:0] pid, iid, input logic [3:0] dlc,
                       input logic [63:0] d, flip);
      send(pid, dlc, d, 1'b0);
      repeat (3) @(posedge pclk);
      send(iid, dlc, ~d ^ flip, 1'b0);
   endtask
endmodule // sdr_remote_node

/* File: tb/tb.sv */
// Self-checking bench for the safety data object receiver.
// Assumes the receiver, its bound checker and the remote node model.
`include "sdr_consts.svh"

module tb import sdr_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TC = 16;
   localparam logic [63:0] PAY = 64'h0000_6655_4433_2211;
   typedef struct {
      logic [7:0] idx;
      sdr_id_t pid;
      sdr_id_t iid;
      sdr_cfg_result_t res;
   } sdr_cfg_row_t;
   sdr_cfg_row_t rows [5] = '{'{8'h00, 11'h181, 11'h182, SDR_CFG_OK},
      '{8'h08, 11'h181, 11'h182, SDR_CFG_BAD_INDEX}, '{8'h00, 11'h123, 11'h123, SDR_CFG_BAD_IDS},
      '{8'h02, 11'h001, 11'h100, SDR_CFG_BAD_IDS}, '{8'h07, 11'h1A0, 11'h1A1, SDR_CFG_OK}};
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic rx_valid, rx_if, rx_ext, new_data_pulse, group_fault, safety_link_fault_flag;
   logic safe_state, global_failsafe_flag, can_std_only;
   logic [10:0] rx_id;
   logic [3:0] rx_dlc, rx_length;
   logic [63:0] rx_data, rx_payload;
   logic [2:0] rx_channel;
   logic [1:0] config_result;
   int fails, total_checks, n;

   sdr_receiver #(.TICK_CYCLES(TC)) sdr_receiver_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_if(rx_if),
      .rx_ext(rx_ext), .rx_id(rx_id), .rx_dlc(rx_dlc), .rx_data(rx_data),
      .rx_payload(rx_payload), .rx_length(rx_length), .rx_channel(rx_channel),
      .new_data_pulse(new_data_pulse), .config_result(config_result),
      .group_fault(group_fault), .safety_link_fault_flag(safety_link_fault_flag),
      .safe_state(safe_state), .global_failsafe_flag(global_failsafe_flag),
      .can_std_only(can_std_only));
   sdr_remote_node sdr_remote_node_i (.pclk(pclk), .rx_valid(rx_valid), .rx_if(rx_if),
      .rx_ext(rx_ext), .rx_id(rx_id), .rx_dlc(rx_dlc), .rx_data(rx_data));

   // ********************
   // Shared tasks
   // ********************
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Returns on the ack edge, request already released
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 50) begin
         fails++;
         give_verdict();
      end
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), exp, rd);
   endtask

   // Which: 0 new data, 1 group fault, 2 failsafe flag
   task automatic wait_sig(input int which);
      logic hit;
      n = 0;
      hit = 1'b0;
      while (!hit && n < 4000) begin
         @(negedge pclk);
         n++;
         hit = which == 0 ? new_data_pulse === 1'b1 :
            which == 1 ? group_fault === 1'b1 : global_failsafe_flag === 1'b1;
      end
      if (!hit) begin
         fails++;
         give_verdict();
      end
   endtask

   task automatic do_reset();
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
   endtask

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   // ********************
   // Main sequence
   // ********************
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      do_reset();
      rdchk(`SDR_OFS_CTRL, `SDR_RST_WORD);
      rdchk(`SDR_OFS_TIMES, `SDR_RST_TIMES);
      apb(1'b1, `SDR_OFS_STATUS, 32'hFFFF_FFFF);
      rdchk(`SDR_OFS_STATUS, `SDR_RST_WORD);
      apb(1'b0, 8'h1C, 32'h0);
      chk("unmapped err", 1'b1, err);
      foreach (rows[i]) begin
         apb(1'b1, `SDR_OFS_INDEX, {24'h0, rows[i].idx});
         apb(1'b1, `SDR_OFS_IDS, {5'h0, rows[i].iid, 5'h0, rows[i].pid});
         apb(1'b1, `SDR_OFS_TIMES, `SDR_RST_TIMES);
         apb(1'b1, `SDR_OFS_CTRL, 32'h0000_0002);
         @(negedge pclk);
         chk("config_result", rows[i].res, config_result);
      end
      sdr_remote_node_i.send(11'h182, 4'h2, 64'h0, 1'b0);
      sdr_remote_node_i.pair(11'h181, 11'h182, 4'h6, PAY, 64'h0);
      apb(1'b1, `SDR_OFS_CTRL, 32'h0000_0001);
      repeat (2) @(negedge pclk);
      chk("can_std_only", 1'b1, can_std_only);
      sdr_remote_node_i.send(11'h182, 4'h1, 64'h0, 1'b1);
      sdr_remote_node_i.pair(11'h181, 11'h182, 4'h6, PAY, 64'h0);
      wait_sig(0);
      chk("service delay", 1'b1, n <= 9 * TC);
      chk("rx_payload", PAY, rx_payload);
      chk("rx_length", 4'h6, rx_length);
      chk("rx_channel", 3'h0, rx_channel);
      chk("group_fault", 1'b0, group_fault);
      rdchk(`SDR_OFS_DATA_LO, PAY[31:0]);
      rdchk(`SDR_OFS_DATA_HI, PAY[63:32]);
      apb(1'b1, `SDR_OFS_CTRL, 32'h0000_0003);
      @(negedge pclk);
      chk("config_result", SDR_CFG_RUNNING, config_result);
      repeat (TC) @(negedge pclk);
      sdr_remote_node_i.pair(11'h181, 11'h182, 4'h6, ~PAY, 64'hFF00_0000_0000_0000);
      wait_sig(0);
      chk("rx_payload", ~PAY, rx_payload);
      sdr_remote_node_i.send(`SDR_GFC_ID, 4'h0, 64'h0, 1'b0);
      wait_sig(2);
      chk("group_fault", 1'b0, group_fault);
      sdr_remote_node_i.pair(11'h181, 11'h182, 4'h6, PAY, 64'h0000_0000_0000_0100);
      wait_sig(1);
      chk("link flag", 1'b1, safety_link_fault_flag);
      chk("safe_state", 1'b1, safe_state);
      apb(1'b1, `SDR_OFS_CTRL, 32'h0000_0000);
      repeat (4) @(negedge pclk);
      chk("fault kept", 1'b1, group_fault);
      for (int i = 0; i < 2; i++) begin
         do_reset();
         apb(1'b1, `SDR_OFS_INDEX, 32'h0);
         apb(1'b1, `SDR_OFS_IDS, 32'h0182_0181);
         apb(1'b1, `SDR_OFS_TIMES, i == 0 ? 32'h0028_0014 : 32'h0003_012C);
         apb(1'b1, `SDR_OFS_CTRL, 32'h0000_0002);
         apb(1'b1, `SDR_OFS_CTRL, 32'h0000_0001);
         if (i == 1) begin
            sdr_remote_node_i.send(11'h181, 4'h8, PAY, 1'b0);
         end
         wait_sig(1);
         if (i == 0) begin
            chk("cycle limit delay", 1'b1, n > 19 * TC && n <= 29 * TC);
         end else begin
            chk("validation delay", 1'b1, n > 2 * TC && n <= 13 * TC);
         end
      end
      give_verdict();
   end
endmodule // tb
